// ### rtl/stpatt_ctrl.sv
// control logic of a digital step attenuator: serial and parallel entry
`timescale 1ns/1ps
// Notes on behaviour
// - serial data bits shift into an internal register on rising shift clock edges
// - strobe high after shifting applies the shifted code to attenuation
// - strobe low holds the attenuation and ignores shift register changes
// - six-bit model takes exactly six bits per update
// - latched parallel: strobe low while lines change, high applies, low latches
// - direct parallel: strobe held high, attenuation follows code lines at once
// - attenuation undefined during a transition; settling flag marks it
// - serial models take start-up attenuation from strap pins
// - all straps low gives 0 dB start state
// - each strap tied high adds its weight to the start code
// - variants without start-up provision always start at 0 dB
module stpatt_ctrl #(
    parameter int unsigned BITS        = stpatt_pkg::CODE_BITS,
    parameter bit          HAS_STARTUP = 1'b1
) (
    input  wire logic            mclk,
    input  wire logic            rstn,
    input  wire logic            parallel_mode,
    input  wire logic            serial_clk,
    input  wire logic            serial_data,
    input  wire logic            update_strobe,
    input  wire logic [BITS-1:0] par_code,
    input  wire logic [BITS-1:0] startup_code,
    output logic      [BITS-1:0] atten_code,
    output logic      [BITS-1:0] shift_code,
    output logic                 settling
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int unsigned SW = BITS + 3;
    logic [SW-1:0] pins_s;

    stpatt_sync #(.W(SW)) u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .din  ({serial_clk, serial_data, update_strobe, par_code}),
        .dout (pins_s)
    );

    logic            sclk_s;
    logic            sdat_s;
    logic            strobe_s;
    logic [BITS-1:0] par_s;
    assign sclk_s   = pins_s[SW-1];
    assign sdat_s   = pins_s[SW-2];
    assign strobe_s = pins_s[SW-3];
    assign par_s    = pins_s[BITS-1:0];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic            sclk_d_ff;
    logic            nxt_sclk_d;
    logic            sclk_rise;
    logic [BITS-1:0] shift_ff;
    logic [BITS-1:0] nxt_shift;
    logic            init_ff;
    logic            nxt_init;
    logic [BITS-1:0] start_val;
    logic [BITS-1:0] target;
    logic            apply;
    logic [BITS-1:0] atten_ff;
    logic [BITS-1:0] nxt_atten;
    logic [4:0]      settle_ff;
    logic [4:0]      nxt_settle;
    logic            settling_ff;
    logic            nxt_settling;

    // ------------------------------------------------------------------
    // serial shift register
    // ------------------------------------------------------------------
    // the edge detector resets to the idle low level of the shift clock,
    // so releasing reset with the shift clock at its idle low level never looks like a shift clock edge
    always_comb begin
        nxt_sclk_d = sclk_s;
        sclk_rise  = sclk_s && !sclk_d_ff && !parallel_mode;
        nxt_shift  = shift_ff;
        if (sclk_rise) begin
            nxt_shift = {shift_ff[BITS-2:0], sdat_s};
        end
        if (!rstn) begin
            nxt_sclk_d = 1'b0;
            nxt_shift  = stpatt_pkg::RESET_CODE[BITS-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        sclk_d_ff <= nxt_sclk_d;
        shift_ff  <= nxt_shift;
    end

    // ------------------------------------------------------------------
    // applied attenuation code
    // ------------------------------------------------------------------
    // straps are caught in the first cycle after reset release, not under
    // reset, so they only need to be settled by the end of reset
    always_comb begin
        if (HAS_STARTUP) begin
            start_val = startup_code;
        end else begin
            start_val = stpatt_pkg::ZERO_DB_CODE[BITS-1:0];
        end
        target    = parallel_mode ? par_s : shift_ff;
        // strobe low: only the start-up load or reset updates the applied code
        apply     = init_ff && strobe_s && (target != atten_ff);
        nxt_init  = 1'b1;
        nxt_atten = atten_ff;
        if (!init_ff) begin
            nxt_atten = start_val;
        end else if (apply) begin
            nxt_atten = target;
        end
        if (!rstn) begin
            nxt_init  = 1'b0;
            nxt_atten = stpatt_pkg::ZERO_DB_CODE[BITS-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        init_ff  <= nxt_init;
        atten_ff <= nxt_atten;
    end

    // ------------------------------------------------------------------
    // settle window
    // ------------------------------------------------------------------
    // every apply restarts the window; the code itself is never delayed, the
    // flag only tells monitoring logic not to trust the output yet
    always_comb begin
        nxt_settle = settle_ff;
        if (apply) begin
            nxt_settle = stpatt_pkg::SETTLE_CNT;
        end else if (settle_ff != 5'h00) begin
            nxt_settle = settle_ff - 5'h01;
        end
        nxt_settling = (nxt_settle != 5'h00);
        if (!rstn) begin
            nxt_settle   = 5'h00;
            nxt_settling = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        settle_ff   <= nxt_settle;
        settling_ff <= nxt_settling;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign atten_code = atten_ff;
    assign shift_code = shift_ff;
    assign settling   = settling_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // start-up load is not a transition: the settle flag is only owed once
    // init has been set for a full cycle
    hold_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        (init_ff && !strobe_s) |=> $stable(atten_ff))
        else $error("attenuation changed with strobe low");

    apply_high_a: assert property (@(posedge mclk) disable iff (!rstn)
        (init_ff && strobe_s && !parallel_mode && !sclk_rise) |=> atten_ff == shift_ff)
        else $error("shifted code not applied");

    shift_in_a: assert property (@(posedge mclk) disable iff (!rstn)
        sclk_rise |=> shift_ff[0] == $past(sdat_s))
        else $error("serial bit not shifted");

    shift_order_a: assert property (@(posedge mclk) disable iff (!rstn)
        sclk_rise |=> shift_ff[BITS-1:1] == $past(shift_ff[BITS-2:0]))
        else $error("older bits not moved up");

    serial_refuse_a: assert property (@(posedge mclk) disable iff (!rstn)
        parallel_mode |=> $stable(shift_ff))
        else $error("serial bit taken in parallel mode");

    direct_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        (init_ff && strobe_s && parallel_mode) |=> atten_ff == $past(par_s))
        else $error("direct mode did not follow lines");

    par_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        (init_ff && parallel_mode && !strobe_s && $changed(par_s)) |=> $stable(atten_ff))
        else $error("parallel lines applied with strobe low");

    settle_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        (init_ff && $past(init_ff) && $changed(atten_ff)) |-> settling_ff)
        else $error("no settling flag on change");

    settle_load_a: assert property (@(posedge mclk) disable iff (!rstn)
        apply |=> (settling_ff && settle_ff == stpatt_pkg::SETTLE_CNT))
        else $error("settle window not started");

    settle_end_a: assert property (@(posedge mclk) disable iff (!rstn)
        (settle_ff == 5'h01 && !apply) |=> !settling_ff)
        else $error("settle window too long");

    startup_a: assert property (@(posedge mclk)
        (rstn && !init_ff) |=> atten_ff == (HAS_STARTUP ? $past(startup_code) : '0))
        else $error("wrong start-up code");

    zero_start_a: assert property (@(posedge mclk)
        (rstn && !init_ff && startup_code == '0) |=> atten_ff == '0)
        else $error("straps low did not give zero code");

    reset_clear_a: assert property (@(posedge mclk)
        !rstn |=> (atten_ff == '0 && !settling_ff))
        else $error("reset did not clear the code");
endmodule : stpatt_ctrl

// ### rtl/stpatt_pkg.sv
// package: constants for the step attenuator control block
package stpatt_pkg;
    // ------------------------------------------------------------------
    // widths and modes
    // ------------------------------------------------------------------
    localparam int unsigned CODE_BITS       = 6;
    localparam logic [5:0]  ZERO_DB_CODE    = 6'h00;
    localparam logic [5:0]  RESET_CODE      = 6'h00;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS   = 25000;
    localparam int unsigned SETTLE_NS       = 400;
    localparam int unsigned SETTLE_CYCLES   = (SETTLE_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [4:0]  SETTLE_CNT      = 5'(SETTLE_CYCLES);
    localparam logic [2:0]  SYNC_RST        = 3'h0;

    typedef enum logic [1:0] {
        STPATT_IF_SERIAL,
        STPATT_IF_PARALLEL
    } stpatt_if_t;
endpackage : stpatt_pkg

// ### rtl/stpatt_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module stpatt_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = rstn ? din : '0;
        nxt_sync = rstn ? meta_ff : '0;
    end

    always_ff @(posedge mclk) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign dout = sync_ff;
endmodule : stpatt_sync

// ### test/stpatt_host.sv
// host controller model driving the attenuator control pins
`timescale 1ns/1ps
module stpatt_host (
    input  wire logic       mclk,
    output logic            serial_clk,
    output logic            serial_data,
    output logic            update_strobe,
    output logic [5:0]      par_code
);
    // --------------------------------------------------------------
    // pin drivers, all changes at the falling edge of mclk
    // --------------------------------------------------------------
    initial begin
        serial_clk    = 1'b0;
        serial_data   = 1'b0;
        update_strobe = 1'b0;
        par_code      = 6'h00;
    end
    // 200 ns link clock, idle low between words; strobe is left as it is here
    task automatic shift_word(input logic [5:0] w);
        for (int i = 5; i >= 0; i--) begin
            @(negedge mclk) serial_data = w[i];
            repeat (2) @(negedge mclk);
            serial_clk = 1'b1;
            repeat (4) @(negedge mclk);
            serial_clk = 1'b0;
            @(negedge mclk);
        end
        repeat (2) @(negedge mclk);
        serial_data = ~serial_data; // released data must not look stale
    endtask : shift_word
    // raised well after the last fall, held 6 cycles, then low to latch
    task automatic pulse_strobe();
        @(negedge mclk) update_strobe = 1'b1;
        repeat (6) @(negedge mclk);
        update_strobe = 1'b0;
    endtask : pulse_strobe
    // 850 ns wait after a pulse also covers the 400 ns settle time
    task automatic settle_wait();
        repeat (34) @(negedge mclk);
    endtask : settle_wait
    task automatic set_par(input logic [5:0] c, input logic strobe);
        @(negedge mclk) par_code = c;
        update_strobe = strobe;
    endtask : set_par
endmodule : stpatt_host

// ### test/tb_top.sv
// testbench for the step attenuator control block
`timescale 1ns/1ps
module tb_top;
    logic       mclk, rstn, parallel_mode, serial_clk, serial_data, update_strobe, settling;
    logic [5:0] par_code, startup_code, atten_code, shift_code, atten_fixed;
    int         miscompares  = 0;
    int         total_checks = 0;
    // --------------------------------------------------------------
    // clock, design, host model
    // --------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    stpatt_ctrl #(.BITS(6), .HAS_STARTUP(1'b1)) i_dut (.mclk(mclk), .rstn(rstn),
        .parallel_mode(parallel_mode), .serial_clk(serial_clk), .serial_data(serial_data),
        .update_strobe(update_strobe), .par_code(par_code), .startup_code(startup_code),
        .atten_code(atten_code), .shift_code(shift_code), .settling(settling));
    stpatt_ctrl #(.BITS(6), .HAS_STARTUP(1'b0)) i_dut_fixed (.mclk(mclk), .rstn(rstn),
        .parallel_mode(parallel_mode), .serial_clk(serial_clk), .serial_data(serial_data),
        .update_strobe(update_strobe), .par_code(par_code), .startup_code(startup_code),
        .atten_code(atten_fixed), .shift_code(), .settling());
    stpatt_host i_host (.mclk(mclk), .serial_clk(serial_clk), .serial_data(serial_data),
        .update_strobe(update_strobe), .par_code(par_code));
    task automatic check(input logic [5:0] got, input logic [5:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic do_reset(input logic [5:0] straps);
        @(negedge mclk) rstn = 1'b0;
        startup_code = straps;
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        check(atten_code, straps);
        check(atten_fixed, 6'h00);
    endtask : do_reset
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        parallel_mode = 1'b0;
        startup_code = 6'h00;
        do_reset(6'h00);
        do_reset(6'h2A);
        i_host.shift_word(6'h35);
        repeat (6) @(negedge mclk);
        check(shift_code, 6'h35);
        check(atten_code, 6'h2A);
        i_host.pulse_strobe();
        check({5'h00, settling}, 6'h01);
        i_host.settle_wait();
        check(atten_code, 6'h35);
        check({5'h00, settling}, 6'h00);
        i_host.shift_word(6'h0C);
        repeat (6) @(negedge mclk);
        check(atten_code, 6'h35);
        parallel_mode = 1'b1;
        i_host.set_par(6'h12, 1'b0);
        repeat (8) @(negedge mclk);
        check(atten_code, 6'h35);
        i_host.pulse_strobe();
        i_host.settle_wait();
        check(atten_code, 6'h12);
        i_host.set_par(6'h21, 1'b1);
        repeat (8) @(negedge mclk);
        check(atten_code, 6'h21);
        i_host.set_par(6'h0C, 1'b1);
        repeat (8) @(negedge mclk);
        check(atten_code, 6'h0C);
        i_host.shift_word(6'h3F);
        repeat (6) @(negedge mclk);
        check(shift_code, 6'h0C);
        check(atten_code, 6'h0C);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end
endmodule : tb_top
